// ---- sttx_device.sv ----
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// Behaviour
// (R01) Host gives byte plus two control bits
// (R02) Bypass forwards ten captured bits unchanged
// (R03) Bypass bit map: data a..g, control h,j
// (R04) Buffer used on host clock, bypassed otherwise
// (R05) Host clock stays within half a character
// (R06) Buffer slip raises error until reinitialized
// (R07) Phase reset latch write recenters buffer
// (R08) Violation character sent while error active
// (R09) Word sync during error recenters and clears
// (R10) Host follows phase reset with word sync
// (R11) Encoder enabled when bypass control is one
// (R12) Two non-overlapping special code tables
// (R13) Characters serialized least significant bit first
// (R14) Control codes: data, fill, special, sync
// (R15) Sync: sixteen K28.5, second/third disparity flipped
// (R16) Sync sequence runs whole, inputs ignored
// (R17) Sync restarts when code seen again
// (R18) Output mux over all character sources
// (R19) Rate select sets bit and character period
// (R20) Self-test ignores the input register
// (R21) Reset: negative disparity, buffer uninitialized
module sttx_device #(
  parameter int BUF_DEPTH = sttx_pkg::BUF_DEPTH,
  parameter int BUF_CENTER = sttx_pkg::BUF_CENTER
) (
  input wire logic clk,
  input wire logic rst,
  sttx_link_if.device link,
  output logic serialData
);

  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam int CB = sttx_pkg::CHAR_BITS;

  typedef enum logic [1:0] {
    WS_IDLE = 2'h0,
    WS_RUN = 2'h1
  } sttx_ws_e;

  function automatic logic [9:0] rev10(input logic [9:0] v);
    logic [9:0] r;
    r = '0;
    for (int i = 0; i < CB; i++)
      r[i] = v[CB - 1 - i];
    return r;
  endfunction : rev10

  // Returns {running disparity after, code abcdei fghj}; rd 1 is positive.
  function automatic logic [10:0] enc8b10b(
    input logic [7:0] b,
    input logic k,
    input logic rd
  );
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s;
    logic [3:0] f;
    logic [9:0] c;
    logic rd6;
    logic alt;
    x = b[4:0];
    y = b[7:5];
    s = sttx_pkg::SIX_B[x];
    rd6 = ($countones(s) != sttx_pkg::SIX_BAL) ? !rd : rd;
    if (rd && ($countones(s) != sttx_pkg::SIX_BAL || x == sttx_pkg::X_D7))
      s = ~s;
    alt = (y == sttx_pkg::Y_7) && (k || (!rd6 && sttx_pkg::ALT_NEG_MASK[x])
      || (rd6 && sttx_pkg::ALT_POS_MASK[x]));
    f = alt ? sttx_pkg::FOUR_ALT : sttx_pkg::FOUR_B[y];
    if (rd6 && ($countones(f) != sttx_pkg::FOUR_BAL || y == sttx_pkg::Y_3))
      f = ~f;
    c = {s, f};
    if (k && x == sttx_pkg::X_K28)
    begin
      c = {sttx_pkg::K28_SIX, sttx_pkg::K28_FOUR[y]};
      if (rd)
        c = ~c;
    end
    return {rd ^ ($countones(c) != sttx_pkg::CODE_BAL), c};
  endfunction : enc8b10b

  logic [9:0] inReg_r;
  logic [9:0] buf_r [BUF_DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W:0] fill_r;
  logic phaseErr_r;
  logic rd_r;
  logic [4:0] charCnt_r;
  logic [9:0] shift_r;
  logic serial_r;
  logic charTick_r;
  sttx_ws_e wsState_r;
  logic [3:0] wsIdx_r;
  logic [8:0] lfsr_r;

  wire encodeOn = link.encoderBypassControl; // see R11
  wire bistOn = link.selftestEnable;
  wire useBuffer = !link.captureClockSelect; // see R04
  wire [4:0] charLast = sttx_pkg::char_last(link.rateSelect);
  wire tick = charCnt_r >= charLast; // see R19
  wire bitStep = !link.rateSelect || charCnt_r[0]; // see R19
  wire wrEn = link.hostTxStrobe && useBuffer;
  wire rdEn = tick && useBuffer;
  wire bufFull = fill_r == (PTR_W + 1)'(BUF_DEPTH);
  wire bufEmpty = fill_r == '0;
  wire overflow = wrEn && bufFull && !rdEn; // see R06
  wire underflow = rdEn && bufEmpty && !wrEn; // see R06
  wire wrDo = wrEn && !overflow;
  wire rdDo = rdEn && !underflow;
  wire errActive = phaseErr_r && useBuffer;
  wire [9:0] charIn = useBuffer ? buf_r[rdPtr_r] : inReg_r;
  wire [1:0] ctlIn = charIn[9:8];
  wire [7:0] byteIn = charIn[7:0];
  wire wsStart = tick && encodeOn && !bistOn && wsState_r == WS_IDLE
    && ctlIn == sttx_pkg::CTL_WSYNC; // see R14, R17
  wire wsBusy = wsStart || wsState_r == WS_RUN; // see R16
  wire recenter = link.phaseAlignReset || (wsStart && errActive); // see R07, R09
  wire [3:0] wsNum = wsStart ? '0 : wsIdx_r;
  wire wsRev = wsNum >= sttx_pkg::WSYNC_REV_FIRST
    && wsNum <= sttx_pkg::WSYNC_REV_LAST; // see R15
  wire wsLast = wsNum == sttx_pkg::WSYNC_LAST;
  wire [PTR_W-1:0] wrPtrNext = wrDo ? wrPtr_r + 1'b1 : wrPtr_r;
  wire [PTR_W-1:0] rdCenter = wrPtrNext - PTR_W'(BUF_CENTER);

  logic [7:0] encByte;
  logic encK;
  logic encRd;
  logic [10:0] encOut;
  logic [9:0] lineChar;
  logic rdNext;

  always_comb
  begin
    encByte = byteIn;
    encK = 1'b0;
    encRd = rd_r;
    if (bistOn)
      encByte = lfsr_r[7:0]; // see R20
    else if (wsBusy)
    begin
      encByte = sttx_pkg::K28_5_BYTE; // see R15
      encK = 1'b1;
      encRd = rd_r ^ wsRev; // see R15
    end
    else
    begin
      case (ctlIn) // see R14
        sttx_pkg::CTL_FILL:
        begin
          encByte = sttx_pkg::K28_5_BYTE;
          encK = 1'b1;
        end
        sttx_pkg::CTL_SPECIAL:
        begin
          encByte = sttx_pkg::special_map(byteIn); // see R12
          encK = 1'b1;
        end
        default:
          encByte = byteIn;
      endcase
    end
  end

  assign encOut = enc8b10b(encByte, encK, encRd);

  // Output mux: self-test, error unless a sync runs, bypass, then running sync or encoder.
  always_comb
  begin
    lineChar = rev10(encOut[9:0]); // see R18
    rdNext = encOut[10];
    if (!bistOn && !wsBusy && errActive)
    begin
      lineChar = rev10(rd_r ? ~sttx_pkg::VIOL_NEG : sttx_pkg::VIOL_NEG); // see R08
      rdNext = rd_r;
    end
    else if (!bistOn && !encodeOn)
    begin
      lineChar = charIn; // see R02, R03
      rdNext = rd_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      inReg_r <= '0;
    else if (link.hostTxStrobe)
      inReg_r <= {link.txCharControl, link.txDataByte}; // see R01
  end

  always_ff @(posedge clk)
  begin
    if (wrDo)
      buf_r[wrPtr_r] <= {link.txCharControl, link.txDataByte}; // see R01
  end

  // Recentering may repeat or skip a queued character; the host covers
  // that by following the reset with a sync sequence.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r <= '0;
      phaseErr_r <= 1'b1; // see R21
    end
    else
    begin
      wrPtr_r <= wrPtrNext;
      rdPtr_r <= recenter ? rdCenter : rdPtr_r + PTR_W'(rdDo);
      fill_r <= recenter ? (PTR_W + 1)'(BUF_CENTER)
        : fill_r + (PTR_W + 1)'(wrDo) - (PTR_W + 1)'(rdDo);
      phaseErr_r <= (overflow || underflow) || (phaseErr_r && !recenter); // see R06
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      charCnt_r <= '0;
      shift_r <= '0;
      serial_r <= 1'b0;
      charTick_r <= 1'b0;
      rd_r <= 1'b0; // see R21
    end
    else
    begin
      charCnt_r <= tick ? '0 : charCnt_r + 5'h01;
      charTick_r <= tick;
      if (tick)
      begin
        serial_r <= lineChar[0]; // see R13
        shift_r <= lineChar >> 1;
        rd_r <= rdNext;
      end
      else if (bitStep)
      begin
        serial_r <= shift_r[0]; // see R13
        shift_r <= shift_r >> 1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wsState_r <= WS_IDLE;
      wsIdx_r <= '0;
      lfsr_r <= sttx_pkg::LFSR_SEED;
    end
    else
    begin
      if (tick && wsBusy && !bistOn)
      begin
        wsState_r <= wsLast ? WS_IDLE : WS_RUN; // see R16
        wsIdx_r <= wsLast ? '0 : wsNum + 4'h1;
      end
      if (!bistOn)
        lfsr_r <= sttx_pkg::LFSR_SEED;
      else if (tick)
        lfsr_r <= {lfsr_r[7:0],
          lfsr_r[sttx_pkg::LFSR_TAP_HI] ^ lfsr_r[sttx_pkg::LFSR_TAP_LO]};
    end
  end

  assign serialData = serial_r;
  assign link.txPhaseError = phaseErr_r;
  assign link.charTick = charTick_r;

endmodule : sttx_device

// ---- sttx_host.sv ----
`timescale 1ns/1ps
module sttx_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  sttx_link_if.host link
);

  logic [3:0] cfg_r;
  logic [9:0] hold_r;
  logic holdFull_r;
  logic ack_r;
  logic [31:0] datO_r;
  logic [4:0] cnt_r;
  logic strobe_r;
  logic [7:0] txData_r;
  logic [1:0] txCtl_r;
  logic paReset_r;

  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire selCfg = wb_adr_i == sttx_pkg::REG_CONFIG;
  wire selPar = wb_adr_i == sttx_pkg::REG_PARESET;
  wire selTx = wb_adr_i == sttx_pkg::REG_TXCHAR;
  wire selStat = wb_adr_i == sttx_pkg::REG_STATUS;
  // A character write waits for the holding slot, stalling the bus.
  wire accept = req && !(selTx && wb_we_i && holdFull_r);
  wire wrLow = accept && wb_we_i && wb_sel_i[0];
  wire wrLoad = wrLow && wb_sel_i[1] && selTx;
  wire [4:0] charLast = sttx_pkg::char_last(cfg_r[sttx_pkg::CFG_RATE]);
  wire sendNow = cnt_r >= charLast; // see R05
  wire [31:0] rdData = selCfg ? 32'(cfg_r)
    : selStat ? 32'({link.txPhaseError, holdFull_r}) : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      datO_r <= '0;
      cfg_r <= sttx_pkg::CFG_RESET;
      paReset_r <= 1'b0;
    end
    else
    begin
      ack_r <= accept;
      datO_r <= accept ? rdData : datO_r;
      if (wrLow && selCfg)
        cfg_r <= wb_dat_i[3:0];
      paReset_r <= wrLow && selPar && !wb_dat_i[0]; // see R07
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hold_r <= '0;
      holdFull_r <= 1'b0;
      cnt_r <= '0;
      strobe_r <= 1'b0;
      txData_r <= '0;
      txCtl_r <= '0;
    end
    else
    begin
      cnt_r <= sendNow ? '0 : cnt_r + 5'h01;
      strobe_r <= sendNow; // see R01
      if (wrLoad)
        hold_r <= wb_dat_i[9:0];
      holdFull_r <= wrLoad || (holdFull_r && !sendNow);
      if (sendNow)
      begin
        txData_r <= holdFull_r ? hold_r[7:0] : sttx_pkg::K28_5_BYTE;
        txCtl_r <= holdFull_r ? hold_r[9:8] : sttx_pkg::CTL_FILL; // see R14
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = datO_r;
  assign link.hostTxStrobe = strobe_r;
  assign link.txDataByte = txData_r;
  assign link.txCharControl = txCtl_r;
  assign link.encoderBypassControl = cfg_r[sttx_pkg::CFG_ENCODE];
  assign link.captureClockSelect = cfg_r[sttx_pkg::CFG_CLKSEL];
  assign link.rateSelect = cfg_r[sttx_pkg::CFG_RATE];
  assign link.selftestEnable = cfg_r[sttx_pkg::CFG_BIST];
  assign link.phaseAlignReset = paReset_r;

endmodule : sttx_host

// ---- sttx_link_if.sv ----
`timescale 1ns/1ps
interface sttx_link_if;
  logic hostTxStrobe;
  logic [7:0] txDataByte;
  logic [1:0] txCharControl;
  logic encoderBypassControl;
  logic captureClockSelect;
  logic rateSelect;
  logic selftestEnable;
  logic phaseAlignReset;
  logic txPhaseError;
  logic charTick;

  modport device (
    input hostTxStrobe,
    input txDataByte,
    input txCharControl,
    input encoderBypassControl,
    input captureClockSelect,
    input rateSelect,
    input selftestEnable,
    input phaseAlignReset,
    output txPhaseError,
    output charTick
  );

  modport host (
    output hostTxStrobe,
    output txDataByte,
    output txCharControl,
    output encoderBypassControl,
    output captureClockSelect,
    output rateSelect,
    output selftestEnable,
    output phaseAlignReset,
    input txPhaseError,
    input charTick
  );
endinterface : sttx_link_if

// ---- sttx_monitor.sv ----
`timescale 1ns/1ps
module sttx_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic hostTxStrobe,
  input wire logic [1:0] txCharControl,
  input wire logic captureClockSelect,
  input wire logic rateSelect,
  input wire logic phaseAlignReset,
  input wire logic txPhaseError,
  input wire logic charTick,
  input wire logic serialData
);
  // Ages saturate: a sync clears the error only characters after its
  // strobe, and a rate change may leave one short bit behind it.
  logic [7:0] initAge_r;
  logic [5:0] rateAge_r;
  logic ratePrev_r;
  wire initEvent = phaseAlignReset ||
    (hostTxStrobe && txCharControl == sttx_pkg::CTL_WSYNC);
  wire [7:0] initAge_nxt = initEvent ? 8'h00 :
    initAge_r + {7'h00, initAge_r != 8'hFF};
  wire [5:0] rateAge_nxt = (rateSelect != ratePrev_r) ? 6'h00 :
    rateAge_r + {5'h00, rateAge_r != 6'h3F};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      initAge_r <= 8'hFF;
      rateAge_r <= 6'h00;
      ratePrev_r <= 1'b0;
    end
    else
    begin
      initAge_r <= initAge_nxt;
      rateAge_r <= rateAge_nxt;
      ratePrev_r <= rateSelect;
    end
  end
  default clocking mc @(posedge clk);
  endclocking
  default disable iff (rst);
  a_tick_gap_min: assert property (charTick |=> !charTick [*8])
    else $error("character tick repeated too soon");
  a_tick_full_rate: assert property (charTick && !rateSelect
    ##1 !rateSelect [*8] ##1 !rateSelect |=> charTick)
    else $error("full rate character period is not 10 clocks");
  a_tick_half_rate: assert property (charTick && rateSelect
    ##1 rateSelect [*8] ##1 rateSelect [*8] ##1 rateSelect [*3]
    |=> charTick)
    else $error("half rate character period is not 20 clocks");
  a_half_bit_hold: assert property (rateSelect &&
    rateAge_r == 6'h3F && $changed(serialData) |=> $stable(serialData))
    else $error("half rate bit shorter than two clocks");
  a_strobe_spacing: assert property (hostTxStrobe |=>
    !hostTxStrobe [*8])
    else $error("host strobes faster than one per character");
  a_reset_state: assert property ($past(rst) && !rst |->
    txPhaseError && !charTick && !serialData)
    else $error("wrong state after reset");
  a_error_clear_cause: assert property ($fell(txPhaseError) |->
    initAge_r < 8'hC8)
    else $error("phase error cleared without reinitialization");
  a_pareset_clears: assert property (phaseAlignReset &&
    !captureClockSelect |-> ##[1:3] !txPhaseError)
    else $error("phase reset did not clear the error");
  a_pareset_pulse: assert property (phaseAlignReset |=>
    !phaseAlignReset)
    else $error("phase reset longer than one cycle");
endmodule : sttx_monitor

// ---- sttx_pkg.sv ----
package sttx_pkg;

  localparam int DATA_BITS = 8;
  localparam int CTRL_BITS = 2;
  localparam int CHAR_BITS = 10;
  localparam int RATE_DIV_FULL = 1;
  localparam int RATE_DIV_HALF = 2;
  localparam logic [4:0] PERIOD_FULL = 5'(CHAR_BITS * RATE_DIV_FULL);
  localparam logic [4:0] PERIOD_HALF = 5'(CHAR_BITS * RATE_DIV_HALF);

  localparam logic [1:0] CTL_DATA = 2'h0;
  localparam logic [1:0] CTL_FILL = 2'h1;
  localparam logic [1:0] CTL_SPECIAL = 2'h2;
  localparam logic [1:0] CTL_WSYNC = 2'h3;

  localparam int WSYNC_LEN = 16;
  localparam logic [3:0] WSYNC_REV_FIRST = 4'h1;
  localparam logic [3:0] WSYNC_REV_LAST = 4'h2;
  localparam logic [3:0] WSYNC_LAST = 4'(WSYNC_LEN - 1);

  localparam int BUF_DEPTH = 4;
  localparam int BUF_CENTER = 2;

  localparam logic [7:0] K28_5_BYTE = 8'hBC;
  // Code words below are written abcdei fghj with a in the top bit.
  localparam logic [9:0] VIOL_NEG = 10'h278;
  localparam logic [8:0] LFSR_SEED = 9'h1FF;
  localparam int LFSR_TAP_HI = 8;
  localparam int LFSR_TAP_LO = 4;

  localparam int SIX_BAL = 3;
  localparam int FOUR_BAL = 2;
  localparam int CODE_BAL = 5;
  localparam logic [4:0] X_D7 = 5'h07;
  localparam logic [4:0] X_K28 = 5'h1C;
  localparam logic [2:0] Y_3 = 3'h3;
  localparam logic [2:0] Y_7 = 3'h7;
  localparam logic [31:0] ALT_NEG_MASK = 32'h0016_0000;
  localparam logic [31:0] ALT_POS_MASK = 32'h0000_6800;
  localparam logic [31:0] K_ALT_MASK = 32'h6880_0000;

  localparam logic [5:0] SIX_B [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] FOUR_B [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [3:0] FOUR_ALT = 4'h7;
  localparam logic [5:0] K28_SIX = 6'h0F;
  localparam logic [3:0] K28_FOUR [8] = '{
    4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};

  // Two special-code tables: small indices below the limit, and the
  // literal control-character byte values above it.
  localparam logic [7:0] SPEC_A_LIMIT = 8'h10;
  localparam int SPEC_A_ALT_BIT = 3;
  localparam logic [4:0] K_ALT_X [4] = '{5'h17, 5'h1B, 5'h1D, 5'h1E};

  localparam int WB_ADR_BITS = 8;
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_PARESET = 8'h04;
  localparam logic [7:0] REG_TXCHAR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CFG_ENCODE = 0;
  localparam int CFG_CLKSEL = 1;
  localparam int CFG_RATE = 2;
  localparam int CFG_BIST = 3;
  localparam logic [3:0] CFG_RESET = 4'h1;
  localparam int STAT_HOLD = 0;
  localparam int STAT_PERR = 1;

  function automatic logic [4:0] char_last(input logic half);
    return half ? PERIOD_HALF - 5'h01 : PERIOD_FULL - 5'h01;
  endfunction : char_last

  function automatic logic [7:0] special_map(input logic [7:0] code);
    logic [7:0] m;
    m = K28_5_BYTE;
    if (code < SPEC_A_LIMIT)
    begin
      if (code[SPEC_A_ALT_BIT])
        m = {Y_7, K_ALT_X[code[1:0]]};
      else
        m = {code[2:0], X_K28};
    end
    else if (code[4:0] == X_K28 || (code[7:5] == Y_7 && K_ALT_MASK[code[4:0]]))
      m = code;
    return m;
  endfunction : special_map

endpackage : sttx_pkg

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbSel = 4'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0000_0000;
  logic [31:0] wbDatO;
  logic wbAck;
  logic serialData;
  logic [31:0] seed = 32'h0001_1474;
  logic [31:0] rdQ[$];
  logic [11:0] expQ[$];
  logic [9:0] rx;
  logic started = 1'b0;
  logic lastInv = 1'b0;
  logic encOn = 1'b1;
  int pos = 99;
  int bad_count = 0;
  int check_count = 0;
  sttx_link_if link ();
  sttx_host sttx_host_i (.clk(clk), .rst(rst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
    .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .link(link));
  sttx_device sttx_device_i (.clk(clk), .rst(rst), .link(link),
    .serialData(serialData));
  sttx_monitor sttx_monitor_i (.clk(clk), .rst(rst),
    .hostTxStrobe(link.hostTxStrobe), .txCharControl(link.txCharControl),
    .captureClockSelect(link.captureClockSelect),
    .rateSelect(link.rateSelect), .phaseAlignReset(link.phaseAlignReset),
    .txPhaseError(link.txPhaseError), .charTick(link.charTick),
    .serialData(serialData));
  always #12.5 clk = ~clk;
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  // Code words are kept with a in the top bit; the line sends a first.
  function automatic logic [9:0] lsbFirst(input logic [9:0] c);
    logic [9:0] r;
    for (int i = 0; i < 10; i++)
      r[i] = c[9 - i];
    return r;
  endfunction : lsbFirst
  function automatic logic [9:0] k28(input int y);
    return lsbFirst({sttx_pkg::K28_SIX, sttx_pkg::K28_FOUR[y]});
  endfunction : k28
  function automatic logic isFill(input logic [9:0] c);
    if (!encOn)
      return c === {sttx_pkg::CTL_FILL, sttx_pkg::K28_5_BYTE};
    return c === k28(5) || c === ~k28(5);
  endfunction : isFill
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbSel <= 4'hF;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= d;
    @(posedge clk);
    while (wbAck !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbSel <= 4'h0;
    if (n == 100)
    begin
      bad_count++;
      summarize();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic tx(input logic [1:0] ctl, input logic [7:0] d);
    wb(1'b1, sttx_pkg::REG_TXCHAR, {22'h0, ctl, d});
  endtask : tx
  task automatic drain();
    int n;
    n = 0;
    while (expQ.size() > 0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(expQ.size()), 32'h0000_0000);
    expQ.delete();
    started = 1'b0;
  endtask : drain
  always @(posedge clk)
    if (wbAck === 1'b1 && wbCyc && !wbWe)
      check(wbDatO, rdQ.pop_front());
  // Fills are skipped only before the first expected character, so any
  // extra or missing character later in a burst shows up as a mismatch.
  always @(posedge clk)
  begin
    int len;
    logic [9:0] e;
    logic [1:0] kd;
    logic inv;
    len = link.rateSelect ? 2 : 1;
    if (link.charTick)
      pos = 0;
    if (pos % len == 0 && pos < 10 * len)
      rx[pos / len] = serialData;
    pos++;
    if (pos == 10 * len && expQ.size() > 0 && (started || !isFill(rx)))
    begin
      {kd, e} = expQ.pop_front();
      inv = (kd == 2'd0) ? (rx === ~e) :
        (kd == 2'd3) ? 1'b0 : (lastInv ^ (kd == 2'd2));
      e = e ^ {10{inv}};
      lastInv = inv;
      check(32'(rx), 32'(e));
      started = expQ.size() > 0;
    end
  end
  initial
  begin
    #2_000_000;
    bad_count++;
    summarize();
  end
  initial
  begin
    logic [31:0] r;
    logic [31:0] perr;
    logic [3:0] cfgs [3];
    cfgs = '{4'h0, 4'h2, 4'h6};
    perr = 32'h1 << sttx_pkg::STAT_PERR;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(sttx_pkg::REG_CONFIG, 32'(sttx_pkg::CFG_RESET));
    rd(sttx_pkg::REG_STATUS, perr);
    wb(1'b1, 8'h10, xorshift());
    rd(8'h10, 32'h0000_0000);
    repeat (3) expQ.push_back({2'd0, lsbFirst(sttx_pkg::VIOL_NEG)});
    drain();
    tx(sttx_pkg::CTL_WSYNC, 8'h00);
    repeat (600) @(posedge clk);
    rd(sttx_pkg::REG_STATUS, 32'h0000_0000);
    $display("test error and clear done");
    for (int t = 0; t < 2; t++)
      for (int y = 0; y < 8; y++)
        if (y != 5)
          expQ.push_back({2'd0, k28(y)});
    for (int t = 0; t < 2; t++)
      for (int y = 0; y < 8; y++)
        if (y != 5)
          tx(sttx_pkg::CTL_SPECIAL, t ? {3'(y), sttx_pkg::X_K28} : 8'(y));
    drain();
    $display("test special tables done");
    expQ.push_back({2'd0, k28(0)});
    repeat (3) expQ.push_back({2'd1, k28(5)});
    repeat (14) expQ.push_back({2'd2, k28(5)});
    // The second sync code lands exactly as the first sequence ends.
    repeat (2) expQ.push_back({2'd1, k28(5)});
    repeat (14) expQ.push_back({2'd2, k28(5)});
    tx(sttx_pkg::CTL_SPECIAL, 8'h00);
    tx(sttx_pkg::CTL_WSYNC, 8'h00);
    repeat (15) tx(sttx_pkg::CTL_SPECIAL, 8'h00);
    tx(sttx_pkg::CTL_WSYNC, 8'h00);
    drain();
    $display("test word sync done");
    for (int m = 0; m < 3; m++)
    begin
      encOn = 1'b0;
      wb(1'b1, sttx_pkg::REG_CONFIG, 32'(cfgs[m]));
      wb(1'b1, sttx_pkg::REG_PARESET, 32'h0000_0000);
      repeat (100) @(posedge clk);
      for (int k = 0; k < 6; k++)
      begin
        r = xorshift();
        if (r[9:0] == {sttx_pkg::CTL_FILL, sttx_pkg::K28_5_BYTE})
          r[0] = ~r[0];
        expQ.push_back({2'd3, r[9:0]});
        tx(r[9:8], r[7:0]);
      end
      drain();
    end
    $display("test bypass modes done");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    encOn = 1'b1;
    rd(sttx_pkg::REG_CONFIG, 32'(sttx_pkg::CFG_RESET));
    wb(1'b1, sttx_pkg::REG_PARESET, 32'h0000_0001);
    rd(sttx_pkg::REG_STATUS, perr);
    wb(1'b1, sttx_pkg::REG_PARESET, 32'h0000_0000);
    tx(sttx_pkg::CTL_WSYNC, 8'h00);
    repeat (10) @(posedge clk);
    rd(sttx_pkg::REG_STATUS, 32'h0000_0000);
    $display("test second reset done");
    summarize();
  end
endmodule : testbench
